// File: logic/eip_ctrl.sv
/*
  External pin interrupt controller with AXI4-Lite registers and vector table.
  Assumes one aclk domain, a core that acknowledges the presented vector,
  and peripheral sources presenting level requests for vectors 4 to 16.
*/
// Behaviour
// - Reset vector is address 0x0000, shared by all reset causes.
// - Dedicated pin vectors to 0x0001, group lo 0x0002, group hi 0x0003.
// - Other sources take fixed vectors 0x0004 through 0x0010.
// - Pins still trigger when driven as outputs by the part itself.
// - Group lo request rises when an enabled pin 7..0 toggles.
// - Group hi request rises when an enabled pin 11..8 toggles.
// - Two per-pin mask registers pick contributing pins per group.
// - Only pin-change inputs set in their group's pin mask are detected for wake-up purposes.
// - Sense field bits 1..0: low, any change, falling, rising.
// - Level mode keeps requesting while the pin stays low.
// - Edge detection needs the running I/O clock.
// - Low level detection serves wake-up from deep sleep.
// - Level dropped before start-up ends wakes without an interrupt.
// - Pin is sampled first; pulses over one clock are caught.
// - Pin interrupt needs mask bit 6 and the global enable.
// - Group hi needs mask bit 5 and global enable; vectors to its entry.
// - Group lo needs mask bit 4 and global enable; vectors to its entry.
// - Mask register bits 7 and 3..0 read zero.
// - Pin flag sets on trigger, clears on entry or write one; zero in level.
// - Group flags set on enabled change, clear on entry or write one.
// - Group lo pin mask: eight read-write bits, reset zero.
`timescale 1ns/1ps
module eip_ctrl
  import eip_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int N_PERIPH = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_pin,
  input wire logic [11:0] pin_change_inputs,
  input wire logic core_global_ie,
  input wire logic [N_PERIPH-1:0] periph_req,
  input wire logic irq_ack,
  output logic irq_req,
  output eip_pkg::eip_vec_t irq_vector,
  output logic wake_req
);
  import eip_pkg::*;

  eip_evt_if evt ();

  eip_ext_sense u_ext (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_irq_pin(ext_irq_pin),
    .evt(evt.ext)
  );

  eip_pin_change #(
    .N_PINS(12),
    .N_LO(8)
  ) u_pc (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_change_inputs(pin_change_inputs),
    .evt(evt.pc)
  );

  // Register state
  logic [7:0] sense_reg;
  logic en_ext_reg;
  logic en_hi_reg;
  logic en_lo_reg;
  logic flag_ext_reg;
  logic flag_hi_reg;
  logic flag_lo_reg;
  logic [7:0] pmask_lo_reg;
  logic [3:0] pmask_hi_reg;
  logic irq_req_reg;
  eip_vec_t irq_vector_reg;
  logic wake_reg;

  // Bus state
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  eip_bus_t wr_state_reg;

  assign evt.sense_mode = sense_reg[1:0];
  assign evt.pin_mask = {pmask_hi_reg, pmask_lo_reg};

  // Write decode
  wire [7:0] w_idx = s_axi_awaddr[9:2];
  wire w_hi_zero = (s_axi_awaddr[ADDR_W-1:10] == '0) && (s_axi_awaddr[1:0] == 2'h0);
  wire w_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire w_lane = s_axi_wstrb[0];
  wire w_sense = w_hi_zero && (w_idx == `EIP_IDX_SENSE);
  wire w_mask = w_hi_zero && (w_idx == `EIP_IDX_MASK);
  wire w_flag = w_hi_zero && (w_idx == `EIP_IDX_FLAG);
  wire w_pmhi = w_hi_zero && (w_idx == `EIP_IDX_PMASK_HI);
  wire w_pmlo = w_hi_zero && (w_idx == `EIP_IDX_PMASK_LO);
  wire w_hit = w_sense | w_mask | w_flag | w_pmhi | w_pmlo;
  wire w_do = w_fire & w_lane;
  wire [7:0] wbyte = s_axi_wdata[7:0];

  // Read decode
  wire [7:0] r_idx = s_axi_araddr[9:2];
  wire r_hi_zero = (s_axi_araddr[ADDR_W-1:10] == '0) && (s_axi_araddr[1:0] == 2'h0);
  wire r_sense = r_hi_zero && (r_idx == `EIP_IDX_SENSE);
  wire r_mask = r_hi_zero && (r_idx == `EIP_IDX_MASK);
  wire r_flag = r_hi_zero && (r_idx == `EIP_IDX_FLAG);
  wire r_pmhi = r_hi_zero && (r_idx == `EIP_IDX_PMASK_HI);
  wire r_pmlo = r_hi_zero && (r_idx == `EIP_IDX_PMASK_LO);
  wire r_hit = r_sense | r_mask | r_flag | r_pmhi | r_pmlo;
  wire r_fire = s_axi_arvalid & s_axi_arready;

  wire [7:0] mask_view = {1'b0, en_ext_reg, en_hi_reg, en_lo_reg, 4'h0};
  wire [7:0] flag_view = {1'b0, flag_ext_reg, flag_hi_reg, flag_lo_reg, 4'h0};
  wire [7:0] rd_byte = r_sense ? sense_reg :
                       r_mask ? mask_view :
                       r_flag ? flag_view :
                       r_pmhi ? {4'h0, pmask_hi_reg} :
                       r_pmlo ? pmask_lo_reg : 8'h00;

  // Flags: set wins over clear
  wire level_mode = (sense_reg[1:0] == `EIP_SENSE_LOW);
  wire ack_take = irq_ack & irq_req_reg;
  wire ack_ext = ack_take && (irq_vector_reg == `EIP_VEC_EXT);
  wire ack_lo = ack_take && (irq_vector_reg == `EIP_VEC_GRP_LO);
  wire ack_hi = ack_take && (irq_vector_reg == `EIP_VEC_GRP_HI);
  wire clr_ext = ack_ext | (w_do & w_flag & wbyte[`EIP_BIT_EXT]);
  wire clr_hi = ack_hi | (w_do & w_flag & wbyte[`EIP_BIT_GRP_HI]);
  wire clr_lo = ack_lo | (w_do & w_flag & wbyte[`EIP_BIT_GRP_LO]);
  wire flag_ext_next = ~level_mode & (evt.ext_edge_evt | (flag_ext_reg & ~clr_ext));
  wire flag_hi_next = evt.grp_hi_evt | (flag_hi_reg & ~clr_hi);
  wire flag_lo_next = evt.grp_lo_evt | (flag_lo_reg & ~clr_lo);

  // Enable updates seen by the arbiter in the same cycle as the write
  wire en_ext_next = (w_do & w_mask) ? wbyte[`EIP_BIT_EXT] : en_ext_reg;
  wire en_hi_next = (w_do & w_mask) ? wbyte[`EIP_BIT_GRP_HI] : en_hi_reg;
  wire en_lo_next = (w_do & w_mask) ? wbyte[`EIP_BIT_GRP_LO] : en_lo_reg;

  // Pending requests in vector order, bit 0 is vector 1
  wire ext_src = level_mode ? evt.ext_low : flag_ext_next;
  wire [N_PERIPH+2:0] pend = {periph_req,
                              flag_hi_next & en_hi_next,
                              flag_lo_next & en_lo_next,
                              ext_src & en_ext_next};

  // Lowest index wins
  function automatic eip_vec_t pick(input logic [N_PERIPH+2:0] p);
    eip_vec_t v;
    v = `EIP_VEC_RESET;
    for (int i = N_PERIPH + 2; i >= 0; i--) begin
      if (p[i]) begin
        v = 5'(i) + `EIP_VEC_EXT;
      end
    end
    return v;
  endfunction : pick

  wire any_pend = |pend;
  wire req_next = core_global_ie & any_pend;
  wire eip_vec_t vec_next = pick(pend);
  // Wake works without the global enable; a low released before entry loses the request
  wire wake_next = (level_mode & evt.ext_low & en_ext_next) |
                   (evt.grp_lo_evt & en_lo_next) | (evt.grp_hi_evt & en_hi_next);

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_reg <= `EIP_RST_SENSE;
      en_ext_reg <= 1'b0;
      en_hi_reg <= 1'b0;
      en_lo_reg <= 1'b0;
      pmask_lo_reg <= `EIP_RST_PMASK;
      pmask_hi_reg <= 4'h0;
    end else begin
      en_ext_reg <= en_ext_next;
      en_hi_reg <= en_hi_next;
      en_lo_reg <= en_lo_next;
      if (w_do & w_sense) begin
        sense_reg <= wbyte;
      end
      if (w_do & w_pmlo) begin
        pmask_lo_reg <= wbyte;
      end
      if (w_do & w_pmhi) begin
        pmask_hi_reg <= wbyte[3:0];
      end
    end
  end

  // Flags and core outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ext_reg <= 1'b0;
      flag_hi_reg <= 1'b0;
      flag_lo_reg <= 1'b0;
      irq_req_reg <= 1'b0;
      irq_vector_reg <= `EIP_VEC_RESET;
      wake_reg <= 1'b0;
    end else begin
      flag_ext_reg <= flag_ext_next;
      flag_hi_reg <= flag_hi_next;
      flag_lo_reg <= flag_lo_next;
      irq_req_reg <= req_next;
      irq_vector_reg <= vec_next;
      wake_reg <= wake_next;
    end
  end

  // Write channel: both address and data must be present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `EIP_RESP_OKAY;
      wr_state_reg <= EIP_BUS_IDLE;
    end else begin
      case (wr_state_reg)
        EIP_BUS_IDLE: begin
          if (w_fire) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= w_hit ? `EIP_RESP_OKAY : `EIP_RESP_SLVERR;
            wr_state_reg <= EIP_BUS_RESP;
          end else begin
            awready_reg <= s_axi_awvalid & s_axi_wvalid;
            wready_reg <= s_axi_awvalid & s_axi_wvalid;
          end
        end
        EIP_BUS_RESP: begin
          if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
            wr_state_reg <= EIP_BUS_IDLE;
          end
        end
        default: begin
          wr_state_reg <= EIP_BUS_IDLE;
        end
      endcase
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `EIP_RESP_OKAY;
    end else if (r_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= r_hit ? `EIP_RESP_OKAY : `EIP_RESP_SLVERR;
    end else if (rvalid_reg) begin
      if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end else begin
      arready_reg <= s_axi_arvalid;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq_req = irq_req_reg;
  assign irq_vector = irq_vector_reg;
  assign wake_req = wake_reg;
endmodule : eip_ctrl

// File: logic/eip_params.svh
/*
  Offsets, field positions, reset values and vector codes for the external
  pin interrupt controller. Assumes inclusion by the package and by modules.
*/
`ifndef EIP_PARAMS_SVH
`define EIP_PARAMS_SVH
// Register indices; byte address is four times the index
`define EIP_IDX_SENSE 8'h15
`define EIP_IDX_MASK 8'h1b
`define EIP_IDX_FLAG 8'h1a
`define EIP_IDX_PMASK_HI 8'h20
`define EIP_IDX_PMASK_LO 8'h12
// Field positions
`define EIP_BIT_EXT 6
`define EIP_BIT_GRP_HI 5
`define EIP_BIT_GRP_LO 4
// Reset values
`define EIP_RST_SENSE 8'h00
`define EIP_RST_PMASK 8'h00
// Sense modes
`define EIP_SENSE_LOW 2'h0
`define EIP_SENSE_ANY 2'h1
`define EIP_SENSE_FALL 2'h2
`define EIP_SENSE_RISE 2'h3
// Vector program addresses
`define EIP_VEC_RESET 5'h00
`define EIP_VEC_EXT 5'h01
`define EIP_VEC_GRP_LO 5'h02
`define EIP_VEC_GRP_HI 5'h03
`define EIP_VEC_WDOG 5'h04
`define EIP_VEC_LAST 5'h10
// AXI responses
`define EIP_RESP_OKAY 2'h0
`define EIP_RESP_SLVERR 2'h2
`endif

// File: logic/eip_pkg.sv
/*
  Types of the external pin interrupt controller.
  Assumes eip_params.svh is on the include path.
*/
package eip_pkg;
  `include "eip_params.svh"
  typedef logic [1:0] eip_sense_t;
  typedef logic [4:0] eip_vec_t;
  typedef enum logic {EIP_BUS_IDLE, EIP_BUS_RESP} eip_bus_t;
endpackage : eip_pkg

// File: logic/eip_evt_if.sv
/*
  Carrier between the controller core and its two pin detectors.
  Assumes all signals live in the aclk domain.
*/
`timescale 1ns/1ps
interface eip_evt_if;
  logic [1:0] sense_mode;
  logic ext_edge_evt;
  logic ext_low;
  logic [11:0] pin_mask;
  logic grp_lo_evt;
  logic grp_hi_evt;
  modport ctrl (output sense_mode, output pin_mask, input ext_edge_evt, input ext_low,
    input grp_lo_evt, input grp_hi_evt);
  modport ext (input sense_mode, output ext_edge_evt, output ext_low);
  modport pc (input pin_mask, output grp_lo_evt, output grp_hi_evt);
endinterface : eip_evt_if

// File: logic/eip_ext_sense.sv
/*
  Dedicated pin detector: synchroniser, edge and level sensing.
  Assumes the pin is an asynchronous input and aclk runs.
*/
`timescale 1ns/1ps
module eip_ext_sense
  import eip_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_irq_pin,
  eip_evt_if.ext evt
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic edge_reg;
  logic low_reg;
  wire rise = sync2_reg & ~prev_reg;
  wire fall = ~sync2_reg & prev_reg;
  logic hit;

  always_comb begin
    case (evt.sense_mode)
      `EIP_SENSE_ANY: hit = rise | fall;
      `EIP_SENSE_FALL: hit = fall;
      `EIP_SENSE_RISE: hit = rise;
      default: hit = 1'b0;
    endcase
  end

  // Pin is sampled, then compared with its previous sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
      edge_reg <= 1'b0;
      low_reg <= 1'b0;
    end else begin
      sync1_reg <= ext_irq_pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      edge_reg <= hit;
      low_reg <= ~sync2_reg;
    end
  end

  assign evt.ext_edge_evt = edge_reg;
  assign evt.ext_low = low_reg;
endmodule : eip_ext_sense

// File: logic/eip_pin_change.sv
/*
  Pin change detector for the twelve inputs, split into two groups.
  Assumes asynchronous pins; each passes a two stage synchroniser.
*/
`timescale 1ns/1ps
module eip_pin_change
  import eip_pkg::*;
#(
  parameter int N_PINS = 12,
  parameter int N_LO = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N_PINS-1:0] pin_change_inputs,
  eip_evt_if.pc evt
);
  logic [N_PINS-1:0] toggle;
  logic lo_reg;
  logic hi_reg;

  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    logic s1_reg;
    logic s2_reg;
    logic prev_reg;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        prev_reg <= 1'b0;
      end else begin
        s1_reg <= pin_change_inputs[i];
        s2_reg <= s1_reg;
        prev_reg <= s2_reg;
      end
    end
    assign toggle[i] = (s2_reg ^ prev_reg) & evt.pin_mask[i];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_reg <= 1'b0;
      hi_reg <= 1'b0;
    end else begin
      lo_reg <= |toggle[N_LO-1:0];
      hi_reg <= |toggle[N_PINS-1:N_LO];
    end
  end

  assign evt.grp_lo_evt = lo_reg;
  assign evt.grp_hi_evt = hi_reg;
endmodule : eip_pin_change

// File: testbench/eip_ctrl_props.sv
/*
  Port checker for eip_ctrl, bound to every instance.
  Assumes one aclk domain with synchronous active low reset.
*/
`timescale 1ns/1ps
module eip_ctrl_props
  import eip_pkg::*;
#(
  parameter int N_PERIPH = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_global_ie,
  input wire logic [N_PERIPH-1:0] periph_req,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire eip_pkg::eip_vec_t irq_vector
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence grp_entry;
    irq_req && irq_ack && irq_vector inside {5'h02, 5'h03};
  endsequence
  reset_clear_a: assert property ($rose(aresetn) |-> !irq_req && irq_vector == 5'h00)
    else $error("request or vector not clear after reset");
  vec_range_a: assert property (irq_req |-> irq_vector inside {[5'h01:5'h10]})
    else $error("vector outside table");
  ge_gate_a: assert property (!core_global_ie [*3] |-> !irq_req)
    else $error("request without global enable");
  prio_low_a: assert property (periph_req[0] && core_global_ie |->
    ##[1:3] irq_req && irq_vector <= 5'h04) else $error("lower vector not served first");
  entry_clear_a: assert property (grp_entry |=> !irq_req || irq_vector != $past(irq_vector))
    else $error("group request stays after entry");
  wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("no write response");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("no read response");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : eip_ctrl_props
bind eip_ctrl eip_ctrl_props #(.N_PERIPH(N_PERIPH)) eip_ctrl_props_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .core_global_ie, .periph_req, .irq_ack, .irq_req, .irq_vector
);

// File: testbench/eip_core_model.sv
/*
  Core interrupt entry model: acknowledges the presented vector.
  Assumes irq_req and irq_vector registered on aclk.
*/
`timescale 1ns/1ps
module eip_core_model
  import eip_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ack_en,
  input wire logic irq_req,
  input wire eip_pkg::eip_vec_t irq_vector,
  output logic irq_ack,
  output eip_pkg::eip_vec_t last_vec
);
  wire take = irq_req && ack_en && !irq_ack;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ack <= 1'b0;
      last_vec <= 5'h00;
    end else begin
      irq_ack <= take;
      if (irq_ack && irq_req) begin
        last_vec <= irq_vector;
      end
    end
  end
endmodule : eip_core_model

// File: testbench/tb_eip_ctrl.sv
/*
  Self-checking bench for eip_ctrl: bus tasks, pin stimulus, random requests.
  Assumes logic/ on the include path and the core model beside the design.
*/
`timescale 1ns/1ps
`include "eip_params.svh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_eip_ctrl;
  import eip_pkg::*;
  localparam logic [11:0] A_SENSE = {2'b00, `EIP_IDX_SENSE, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, `EIP_IDX_MASK, 2'b00};
  localparam logic [11:0] A_FLAG = {2'b00, `EIP_IDX_FLAG, 2'b00};
  localparam logic [11:0] A_PHI = {2'b00, `EIP_IDX_PMASK_HI, 2'b00};
  localparam logic [11:0] A_PLO = {2'b00, `EIP_IDX_PMASK_LO, 2'b00};
  logic [11:0] regs [5] = '{A_SENSE, A_MASK, A_FLAG, A_PHI, A_PLO};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000, pins = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ext_pin = 1'b1, ge = 1'b0, ack_en = 1'b0;
  logic [12:0] periph = 13'h0, p13;
  logic awready, wready, bvalid, arready, rvalid, wake_req, irq_req, irq_ack;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic [7:0] d8;
  eip_vec_t irq_vector, last_vec;
  int errors = 0, total_checks = 0, cycles = 0, k, j;
  integer seed = 32'h1c79112e;
  eip_ctrl eip_ctrl_i (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_irq_pin(ext_pin), .pin_change_inputs(pins), .core_global_ie(ge),
    .periph_req(periph), .irq_ack, .irq_req, .irq_vector, .wake_req
  );
  eip_core_model eip_core_model_i (.aclk, .aresetn, .ack_en, .irq_req, .irq_vector,
    .irq_ack, .last_vec);
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    tick($unsigned($random(seed)) % 3);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    tick($unsigned($random(seed)) % 3);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
  endtask : rdc
  task automatic flip(input int n);
    @(posedge aclk);
    pins[n] <= ~pins[n];
  endtask : flip
  function automatic logic [31:0] ext_flag(input int m, input bit fall);
    return (m == `EIP_SENSE_ANY || (m == `EIP_SENSE_FALL && fall) ||
      (m == `EIP_SENSE_RISE && !fall)) ? 32'h40 : 32'h0;
  endfunction : ext_flag
  function automatic eip_vec_t first_vec(input logic [12:0] p);
    eip_vec_t v;
    v = 5'h00;
    for (int i = 12; i >= 0; i--) begin
      if (p[i]) begin
        v = `EIP_VEC_WDOG + 5'(i);
      end
    end
    return v;
  endfunction : first_vec
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    tick(6);
    aresetn <= 1'b1;
    foreach (regs[i]) rdc(regs[i], 32'h0, `EIP_RESP_OKAY);
    wr(A_MASK, 8'hff);
    rdc(A_MASK, 32'h70, `EIP_RESP_OKAY);
    wr(A_PHI, 8'hff);
    rdc(A_PHI, 32'h0f, `EIP_RESP_OKAY);
    d8 = $random(seed);
    wr(A_PLO, d8);
    rdc(A_PLO, {24'h0, d8}, `EIP_RESP_OKAY);
    wr(12'h004, 8'h5a);
    `CHK("bresp", `EIP_RESP_SLVERR, r)
    rdc(12'h004, 32'h0, `EIP_RESP_SLVERR);
    rdc(A_SENSE + 12'h1, 32'h0, `EIP_RESP_SLVERR);
    ge <= 1'b1;
    ack_en <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      k = g * 8 + $unsigned($random(seed)) % (g ? 4 : 8);
      j = g * 8 + (k - g * 8 + 1) % (g ? 4 : 8);
      wr(A_PLO, g ? 8'h00 : 8'h01 << k);
      wr(A_PHI, g ? 8'h01 << (k - 8) : 8'h00);
      wr(A_MASK, g ? 8'h20 : 8'h10);
      flip(j);
      tick(12);
      rdc(A_FLAG, 32'h0, `EIP_RESP_OKAY);
      flip(k);
      tick(12);
      `CHK("served", `EIP_VEC_GRP_LO + 5'(g), last_vec)
      rdc(A_FLAG, 32'h0, `EIP_RESP_OKAY);
    end
    ge <= 1'b0;
    flip(k);
    tick(12);
    rdc(A_FLAG, 32'h20, `EIP_RESP_OKAY);
    `CHK("irq_req", 1'b0, irq_req)
    wr(A_FLAG, 8'h20);
    rdc(A_FLAG, 32'h0, `EIP_RESP_OKAY);
    wr(A_MASK, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wr(A_SENSE, 8'(m));
      wr(A_FLAG, 8'h40);
      ext_pin <= 1'b0;
      tick(8);
      rdc(A_FLAG, ext_flag(m, 1'b1), `EIP_RESP_OKAY);
      wr(A_FLAG, 8'h40);
      ext_pin <= 1'b1;
      tick(8);
      rdc(A_FLAG, ext_flag(m, 1'b0), `EIP_RESP_OKAY);
    end
    wr(A_SENSE, 8'(`EIP_SENSE_LOW));
    ack_en <= 1'b0;
    ext_pin <= 1'b0;
    tick(8);
    `CHK("irq_req", 1'b0, irq_req)
    `CHK("wake_req", 1'b1, wake_req)
    ge <= 1'b1;
    tick(8);
    `CHK("irq_req", 1'b1, irq_req)
    `CHK("vector", `EIP_VEC_EXT, irq_vector)
    ext_pin <= 1'b1;
    tick(8);
    `CHK("irq_req", 1'b0, irq_req)
    `CHK("wake_req", 1'b0, wake_req)
    wr(A_MASK, 8'h70);
    wr(A_PLO, 8'h01);
    wr(A_PHI, 8'h01);
    periph <= 13'h1 | 13'($random(seed));
    @(posedge aclk);
    pins <= pins ^ 12'h101;
    tick(12);
    `CHK("vector", `EIP_VEC_GRP_LO, irq_vector)
    periph <= 13'h0;
    ack_en <= 1'b1;
    tick(20);
    `CHK("served", `EIP_VEC_GRP_HI, last_vec)
    ack_en <= 1'b0;
    repeat (4) begin
      p13 = $random(seed);
      p13[12] = 1'b1;
      periph <= p13;
      tick(6);
      `CHK("vector", first_vec(p13), irq_vector)
    end
    periph <= 13'h0;
    tick(4);
    end_of_test();
  end
endmodule : tb_eip_ctrl
